// ===== fsp_defs.svh
// addresses, codes and reset values of the self-programming command registers
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
`define FSP_ADDR_CMD 16'hFFA3
`define FSP_ADDR_PTR_LOW 16'hFFA4
`define FSP_ADDR_PTR_HIGH 16'hFFA5
`define FSP_ADDR_CMP_HIGH 16'hFFA6
`define FSP_ADDR_CMP_LOW 16'hFFA7
`define FSP_ADDR_WDATA 16'hFFA8
`define FSP_ADDR_PROTECT 12'h081
`define FSP_CMD_NONE 3'h0
`define FSP_CMD_VERIFY1 3'h1
`define FSP_CMD_VERIFY2 3'h2
`define FSP_CMD_ERASE 3'h3
`define FSP_CMD_BLANK 3'h4
`define FSP_CMD_WRITE 3'h5
`define FSP_CMD_RESET 3'h0
`define FSP_CMP_RESET 8'h00
`define FSP_WDATA_RESET 8'h00
`define FSP_PROT_LSB 2
`define FSP_PROT_MSB 6
`define FSP_PROT_BLK3_0 5'h0E
`define FSP_PROT_BLK1_0 5'h0F
`define FSP_PROT_NONE 5'h1F
`define FSP_BLK_TOP_3 4'h3
`define FSP_BLK_TOP_1 4'h1
`define FSP_BLANK_VALUE 8'hFF
`define FSP_FULL_BYTE 8'hFF
`endif

// ===== fsp_pkg.sv
// types shared by the self-programming command block
`default_nettype none
package fsp_pkg;
    typedef enum logic [2:0] {FSP_ST_PB_REQ, FSP_ST_PB_WAIT, FSP_ST_IDLE, FSP_ST_RD,
                              FSP_ST_ERASE, FSP_ST_WRITE, FSP_ST_DONE} fsp_state_e;
    typedef enum logic [1:0] {FSP_OP_READ, FSP_OP_WRITE, FSP_OP_ERASE} fsp_op_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] bmask;
    } fsp_bus_s;
    typedef struct packed {
        logic start;
        fsp_op_e op;
        logic [11:0] addr;
        logic [7:0] wdata;
    } fsp_flash_req_s;
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic fail;
    } fsp_flash_rsp_s;
endpackage : fsp_pkg
`default_nettype wire

// ===== fsp_cmd_regs.sv
// command registers and sequencer for flash self programming
//
// Functional notes
// - command register: 3-bit code, bits 7..3 zero, reset 00, bit or byte writes
// - code 001 verifies a whole block; failure sets an error flag
// - code 010 verifies several addresses of a block; failure sets an error flag
// - code 011 erases the block selected by the address registers
// - code 100 checks that every location of the block is erased
// - code 101 programs the write buffer byte at the pointer address
// - programming a 1 onto an unerased 0 sets the protect error flag
// - undefined codes abort at once and set an error flag
// - 12-bit start address from high pointer bits 3..0 and low pointer byte
// - pointers count up to the compare registers outside command execution
// - pointers have no defined reset value
// - 8-bit write buffer, whole-byte writes only, reset to zero
// - protect byte bits 6..2 read from flash; applies only in self programming
// - protect codes: 01110 blocks 3..0, 01111 blocks 1..0, 11111 none
// - a halt in self programming mode starts the loaded command
// - a command on a protected block sets the protect error flag
// - error flags stay set until cleared by software or reset
`include "fsp_defs.svh"
`default_nettype none
module fsp_cmd_regs
    import fsp_pkg::*;
#(
    parameter int NUM_BLOCKS = 4
)(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire fsp_bus_s bus_i,
    output logic [7:0] rdata_o,
    input wire logic halt_i,
    input wire logic self_program_mode_select_i,
    input wire logic verify_error_clr_i,
    input wire logic protect_error_clr_i,
    output logic verify_error_flag_o,
    output logic write_erase_protect_error_flag_o,
    output logic cpu_hold_o,
    output fsp_flash_req_s flash_o,
    input wire fsp_flash_rsp_s flash_i
);
    if (NUM_BLOCKS != 4) begin : g_bad_blocks
        $error("fsp_cmd_regs decodes the protect field for four blocks only");
    end

    fsp_state_e state_reg;
    logic [2:0] cmd_reg;
    logic [7:0] ptr_low_reg;
    logic [7:0] ptr_high_reg;
    logic [7:0] cmp_low_reg;
    logic [7:0] cmp_high_reg;
    logic [7:0] wdata_reg;
    logic [4:0] prot_reg;
    logic [11:0] ptr_addr;
    logic wr_cmd, wr_pl, wr_ph, wr_cl, wr_ch, wr_wd;
    logic cmd_start, cmd_valid, blk_protected, at_end, rd_ok, ptr_step, idle_count;
    logic verr_set, perr_set;

    // register strobes
    assign wr_cmd = bus_i.wr && (bus_i.addr == `FSP_ADDR_CMD);
    assign wr_pl = bus_i.wr && (bus_i.addr == `FSP_ADDR_PTR_LOW);
    assign wr_ph = bus_i.wr && (bus_i.addr == `FSP_ADDR_PTR_HIGH);
    assign wr_ch = bus_i.wr && (bus_i.addr == `FSP_ADDR_CMP_HIGH);
    assign wr_cl = bus_i.wr && (bus_i.addr == `FSP_ADDR_CMP_LOW);
    assign wr_wd = bus_i.wr && (bus_i.addr == `FSP_ADDR_WDATA);

    assign ptr_addr = {ptr_high_reg[3:0], ptr_low_reg};
    assign at_end = (ptr_high_reg == cmp_high_reg) && (ptr_low_reg == cmp_low_reg);

    assign cmd_valid = (cmd_reg != `FSP_CMD_NONE) && (cmd_reg <= `FSP_CMD_WRITE);
    assign cmd_start = (state_reg == FSP_ST_IDLE) && halt_i && self_program_mode_select_i
                       && (cmd_reg != `FSP_CMD_NONE);

    // prohibited codes fence every block, the safe reading of a bad setting
    always_comb
    begin
        case (prot_reg)
            `FSP_PROT_BLK3_0: blk_protected = (ptr_high_reg[3:0] <= `FSP_BLK_TOP_3);
            `FSP_PROT_BLK1_0: blk_protected = (ptr_high_reg[3:0] <= `FSP_BLK_TOP_1);
            `FSP_PROT_NONE: blk_protected = 1'b0;
            default: blk_protected = 1'b1;
        endcase
        blk_protected = blk_protected && self_program_mode_select_i;
    end

    // read result check, one location per acknowledge
    always_comb
    begin
        case (cmd_reg)
            `FSP_CMD_BLANK: rd_ok = (flash_i.rdata == `FSP_BLANK_VALUE);
            `FSP_CMD_WRITE: rd_ok = ((wdata_reg & ~flash_i.rdata) == 8'h00);
            default: rd_ok = !flash_i.fail;
        endcase
    end

    assign ptr_step = (state_reg == FSP_ST_RD) && flash_i.ack && rd_ok
                      && (cmd_reg != `FSP_CMD_WRITE) && !at_end;
    assign idle_count = (state_reg == FSP_ST_IDLE) && !cmd_start && !at_end
                        && !wr_pl && !wr_ph;

    // error causes
    assign verr_set = (cmd_start && !cmd_valid)
                      || ((state_reg == FSP_ST_RD) && flash_i.ack && !rd_ok
                          && (cmd_reg != `FSP_CMD_WRITE))
                      || (((state_reg == FSP_ST_ERASE) || (state_reg == FSP_ST_WRITE))
                          && flash_i.ack && flash_i.fail);
    assign perr_set = (cmd_start && cmd_valid && blk_protected)
                      || ((state_reg == FSP_ST_RD) && flash_i.ack && !rd_ok
                          && (cmd_reg == `FSP_CMD_WRITE));

    // command register, bitwise writable, upper bits never stored
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            cmd_reg <= `FSP_CMD_RESET;
        else if (wr_cmd)
            cmd_reg <= (cmd_reg & ~bus_i.bmask[2:0]) | (bus_i.wdata[2:0] & bus_i.bmask[2:0]);
    end

    // pointers carry no reset; software reloads them before each command
    always_ff @(posedge clk_i)
    begin
        if (wr_pl)
            ptr_low_reg <= (ptr_low_reg & ~bus_i.bmask) | (bus_i.wdata & bus_i.bmask);
        else if (ptr_step || idle_count)
            ptr_low_reg <= ptr_low_reg + 8'h01;
        if (wr_ph)
            ptr_high_reg <= (ptr_high_reg & ~bus_i.bmask) | (bus_i.wdata & bus_i.bmask);
        else if ((ptr_step || idle_count) && (ptr_low_reg == 8'hFF))
            ptr_high_reg <= ptr_high_reg + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            cmp_low_reg <= `FSP_CMP_RESET;
            cmp_high_reg <= `FSP_CMP_RESET;
        end
        else
        begin
            if (wr_cl)
                cmp_low_reg <= (cmp_low_reg & ~bus_i.bmask) | (bus_i.wdata & bus_i.bmask);
            if (wr_ch)
                cmp_high_reg <= (cmp_high_reg & ~bus_i.bmask) | (bus_i.wdata & bus_i.bmask);
        end
    end

    // write buffer ignores single-bit writes
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            wdata_reg <= `FSP_WDATA_RESET;
        else if (wr_wd && (bus_i.bmask == `FSP_FULL_BYTE))
            wdata_reg <= bus_i.wdata;
    end

    // read port, unmapped addresses answer zero
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            rdata_o <= 8'h00;
        else if (bus_i.rd)
        begin
            if (bus_i.addr == `FSP_ADDR_CMD)
                rdata_o <= {5'h00, cmd_reg};
            else if (bus_i.addr == `FSP_ADDR_PTR_LOW)
                rdata_o <= ptr_low_reg;
            else if (bus_i.addr == `FSP_ADDR_PTR_HIGH)
                rdata_o <= ptr_high_reg;
            else if (bus_i.addr == `FSP_ADDR_CMP_HIGH)
                rdata_o <= cmp_high_reg;
            else if (bus_i.addr == `FSP_ADDR_CMP_LOW)
                rdata_o <= cmp_low_reg;
            else if (bus_i.addr == `FSP_ADDR_WDATA)
                rdata_o <= wdata_reg;
            else
                rdata_o <= 8'h00;
        end
    end

    // sticky error flags; a set in the clearing cycle wins
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            verify_error_flag_o <= 1'b0;
            write_erase_protect_error_flag_o <= 1'b0;
        end
        else
        begin
            verify_error_flag_o <= verr_set || (verify_error_flag_o && !verify_error_clr_i);
            write_erase_protect_error_flag_o <= perr_set
                || (write_erase_protect_error_flag_o && !protect_error_clr_i);
        end
    end

    // protect byte latched once after reset
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            prot_reg <= `FSP_PROT_NONE;
        else if ((state_reg == FSP_ST_PB_WAIT) && flash_i.ack)
            prot_reg <= flash_i.rdata[`FSP_PROT_MSB:`FSP_PROT_LSB];
    end

    // sequencer
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= FSP_ST_PB_REQ;
            cpu_hold_o <= 1'b0;
            flash_o <= '{start: 1'b0, op: FSP_OP_READ, addr: `FSP_ADDR_PROTECT, wdata: 8'h00};
        end
        else
        begin
            flash_o.start <= 1'b0;
            case (state_reg)
                FSP_ST_PB_REQ:
                begin
                    flash_o <= '{start: 1'b1, op: FSP_OP_READ, addr: `FSP_ADDR_PROTECT,
                                 wdata: 8'h00};
                    state_reg <= FSP_ST_PB_WAIT;
                end
                FSP_ST_PB_WAIT:
                    if (flash_i.ack)
                        state_reg <= FSP_ST_IDLE;
                FSP_ST_IDLE:
                    if (cmd_start)
                    begin
                        cpu_hold_o <= 1'b1;
                        flash_o.addr <= ptr_addr;
                        flash_o.wdata <= wdata_reg;
                        if (!cmd_valid || blk_protected)
                            state_reg <= FSP_ST_DONE;
                        else if (cmd_reg == `FSP_CMD_ERASE)
                        begin
                            flash_o.start <= 1'b1;
                            flash_o.op <= FSP_OP_ERASE;
                            state_reg <= FSP_ST_ERASE;
                        end
                        else
                        begin
                            flash_o.start <= 1'b1;
                            flash_o.op <= FSP_OP_READ;
                            state_reg <= FSP_ST_RD;
                        end
                    end
                FSP_ST_RD:
                    if (flash_i.ack)
                    begin
                        if (!rd_ok)
                            state_reg <= FSP_ST_DONE;
                        else if (cmd_reg == `FSP_CMD_WRITE)
                        begin
                            flash_o.start <= 1'b1;
                            flash_o.op <= FSP_OP_WRITE;
                            state_reg <= FSP_ST_WRITE;
                        end
                        else if (at_end)
                            state_reg <= FSP_ST_DONE;
                        else
                        begin
                            flash_o.start <= 1'b1;
                            flash_o.addr <= flash_o.addr + 12'h001;
                        end
                    end
                FSP_ST_ERASE, FSP_ST_WRITE:
                    if (flash_i.ack)
                        state_reg <= FSP_ST_DONE;
                FSP_ST_DONE:
                begin
                    cpu_hold_o <= 1'b0;
                    state_reg <= FSP_ST_IDLE;
                end
                default:
                    state_reg <= FSP_ST_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence seq_start_valid;
        cmd_start && cmd_valid && !blk_protected;
    endsequence
    sequence seq_write_clash;
        (state_reg == FSP_ST_RD) && flash_i.ack && (cmd_reg == `FSP_CMD_WRITE)
        && ((wdata_reg & ~flash_i.rdata) != 8'h00);
    endsequence

    chk_cmd_upper_zero: assert property (bus_i.rd && (bus_i.addr == `FSP_ADDR_CMD)
        |=> rdata_o[7:3] == 5'h00) else $error("command read shows upper bits");
    chk_bad_cmd_abort: assert property (cmd_start && !cmd_valid
        |=> verify_error_flag_o && (state_reg == FSP_ST_DONE) && !flash_o.start)
        else $error("undefined command not aborted");
    chk_blank_fail: assert property ((state_reg == FSP_ST_RD) && flash_i.ack
        && (cmd_reg == `FSP_CMD_BLANK) && (flash_i.rdata != `FSP_BLANK_VALUE)
        |=> verify_error_flag_o) else $error("blank check miss not flagged");
    chk_write_unerased: assert property (seq_write_clash
        |=> write_erase_protect_error_flag_o && !flash_o.start)
        else $error("write over unerased bit not refused");
    chk_protect_block: assert property (cmd_start && cmd_valid && blk_protected
        |=> write_erase_protect_error_flag_o ##1 !cpu_hold_o)
        else $error("protected block not fenced");
    chk_erase_issue: assert property (seq_start_valid and (cmd_reg == `FSP_CMD_ERASE)
        |=> flash_o.start && (flash_o.op == FSP_OP_ERASE) && (flash_o.addr == $past(ptr_addr)))
        else $error("erase not issued at block");
    chk_flag_sticky: assert property (verify_error_flag_o && !verify_error_clr_i
        |=> verify_error_flag_o) else $error("verify flag lost");
    chk_perr_sticky: assert property (write_erase_protect_error_flag_o
        && !protect_error_clr_i |=> write_erase_protect_error_flag_o)
        else $error("protect flag lost");
    chk_hold_cycle: assert property (cmd_start |=> cpu_hold_o ##0
        (cpu_hold_o throughout (state_reg != FSP_ST_IDLE)[*1]))
        else $error("processor not held on start");
    chk_hold_release: assert property ((state_reg == FSP_ST_DONE) |=> !cpu_hold_o
        && (state_reg == FSP_ST_IDLE)) else $error("processor not released");
    chk_ptr_count: assert property (idle_count
        |=> ptr_low_reg == $past(ptr_low_reg) + 8'h01)
        else $error("pointer did not count toward compare");
    chk_wbuf_byte: assert property (wr_wd && (bus_i.bmask != `FSP_FULL_BYTE)
        |=> $stable(wdata_reg)) else $error("write buffer took a partial write");
endmodule : fsp_cmd_regs
`default_nettype wire

// ===== fsp_flash_model.sv
// behavioural flash array answering the self-programming sequencer
`default_nettype none
module fsp_flash_model
    import fsp_pkg::*;
(
    input wire logic clk_i,
    input wire fsp_flash_req_s req_i,
    input wire logic fail_i,
    input wire logic slow_i,
    output fsp_flash_rsp_s rsp_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:4095];
    fsp_flash_req_s cur;
    int wait_cnt;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hFF;
        mem[12'h081] = 8'hBF;
        rsp_o = '0;
        wait_cnt = -1;
    end
    always @(posedge clk_i)
    begin
        rsp_o.ack <= 1'b0;
        rsp_o.fail <= 1'b0;
        // idle bus toggles so a stale byte is never mistaken for data
        rsp_o.rdata <= ~rsp_o.rdata;
        if (req_i.start)
        begin
            cur <= req_i;
            wait_cnt <= slow_i ? 6 : 1;
        end
        else if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
        else if (wait_cnt == 0)
        begin
            wait_cnt <= -1;
            rsp_o.ack <= 1'b1;
            rsp_o.fail <= fail_i;
            case (cur.op)
                FSP_OP_READ: rsp_o.rdata <= mem[cur.addr];
                // programming can only clear bits, like a real cell
                FSP_OP_WRITE: mem[cur.addr] <= mem[cur.addr] & cur.wdata;
                default:
                    for (int i = 0; i < 256; i++)
                        mem[{cur.addr[11:8], 8'(i)}] <= 8'hFF;
            endcase
        end
    end
endmodule : fsp_flash_model
`default_nettype wire

// ===== testbench.sv
// self-checking testbench for the flash self-programming command block
`include "fsp_defs.svh"
`default_nettype none
module testbench
    import fsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    fsp_bus_s bus = '0;
    logic [7:0] rdata;
    logic halt_i = 1'b0;
    logic self_mode = 1'b1;
    logic v_clr = 1'b0;
    logic p_clr = 1'b0;
    logic v_flag;
    logic p_flag;
    logic cpu_hold;
    logic fail_knob = 1'b0;
    logic slow_knob = 1'b0;
    fsp_flash_req_s freq;
    fsp_flash_rsp_s frsp;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    fsp_cmd_regs #(.NUM_BLOCKS(4)) DUT (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus),
        .rdata_o(rdata), .halt_i(halt_i), .self_program_mode_select_i(self_mode),
        .verify_error_clr_i(v_clr), .protect_error_clr_i(p_clr),
        .verify_error_flag_o(v_flag), .write_erase_protect_error_flag_o(p_flag),
        .cpu_hold_o(cpu_hold), .flash_o(freq), .flash_i(frsp));
    fsp_flash_model flash_mem (.clk_i(clk_i), .req_i(freq), .fail_i(fail_knob),
        .slow_i(slow_knob), .rsp_o(frsp));
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
        bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, bmask: m};
        @(negedge clk_i);
        bus.wr = 1'b0;
        @(negedge clk_i);
    endtask : bus_wr
    task automatic bus_rd(input logic [15:0] a, input logic [7:0] e);
        bus.rd = 1'b1;
        bus.addr = a;
        @(negedge clk_i);
        bus.rd = 1'b0;
        check(rdata, e);
        @(negedge clk_i);
    endtask : bus_rd
    // command written before the pointers so they step at most once before the halt
    task automatic do_cmd(input logic [7:0] cmd, input logic [7:0] ph, input logic [7:0] pl,
                          input logic [7:0] cl, input logic [1:0] flags, input logic busy);
        int n;
        n = 0;
        bus_wr(`FSP_ADDR_CMD, cmd, `FSP_FULL_BYTE);
        bus_wr(`FSP_ADDR_CMP_HIGH, ph, `FSP_FULL_BYTE);
        bus_wr(`FSP_ADDR_CMP_LOW, cl, `FSP_FULL_BYTE);
        bus_wr(`FSP_ADDR_PTR_HIGH, ph, `FSP_FULL_BYTE);
        bus_wr(`FSP_ADDR_PTR_LOW, pl, `FSP_FULL_BYTE);
        halt_i = 1'b1;
        @(negedge clk_i);
        halt_i = 1'b0;
        check({7'h00, cpu_hold}, {7'h00, busy});
        while (cpu_hold === 1'b1 && n < 3000)
        begin
            @(negedge clk_i);
            n++;
        end
        repeat (3) @(negedge clk_i);
        check({6'h00, v_flag, p_flag}, {6'h00, flags});
        v_clr = 1'b1;
        p_clr = 1'b1;
        @(negedge clk_i);
        v_clr = 1'b0;
        p_clr = 1'b0;
        @(negedge clk_i);
        check({6'h00, v_flag, p_flag}, 8'h00);
    endtask : do_cmd
    // protect byte is only read after reset, so each new code needs one
    task automatic do_reset(input logic [7:0] pb);
        flash_mem.mem[12'h081] = pb;
        nrst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (20) @(negedge clk_i);
    endtask : do_reset
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // longest run is two blank checks, one stopping at the first unerased byte and one at 255 reads
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fail_count++;
            test_done;
        end
    end
    initial
    begin
        do_reset(8'hBF);
        bus_rd(`FSP_ADDR_CMD, `FSP_CMD_RESET);
        bus_rd(`FSP_ADDR_CMP_HIGH, `FSP_CMP_RESET);
        bus_rd(`FSP_ADDR_CMP_LOW, `FSP_CMP_RESET);
        bus_rd(`FSP_ADDR_WDATA, `FSP_WDATA_RESET);
        bus_wr(`FSP_ADDR_CMD, 8'hFF, 8'hFF);
        bus_rd(`FSP_ADDR_CMD, 8'h07);
        bus_wr(`FSP_ADDR_CMD, 8'h00, 8'h01);
        bus_rd(`FSP_ADDR_CMD, 8'h06);
        bus_wr(`FSP_ADDR_WDATA, 8'h5A, 8'hFF);
        bus_wr(`FSP_ADDR_WDATA, 8'h00, 8'h01);
        bus_rd(`FSP_ADDR_WDATA, 8'h5A);
        $display("test registers done");
        bus_wr(`FSP_ADDR_CMP_HIGH, 8'h03, 8'hFF);
        bus_wr(`FSP_ADDR_CMP_LOW, 8'h02, 8'hFF);
        bus_wr(`FSP_ADDR_PTR_HIGH, 8'h02, 8'hFF);
        bus_wr(`FSP_ADDR_PTR_LOW, 8'hFE, 8'hFF);
        repeat (10) @(negedge clk_i);
        bus_rd(`FSP_ADDR_PTR_LOW, 8'h02);
        bus_rd(`FSP_ADDR_PTR_HIGH, 8'h03);
        $display("test pointer_count done");
        flash_mem.mem[12'h000] = 8'h00;
        flash_mem.mem[12'h200] = 8'h00;
        for (int b = 0; b < 4; b++)
        begin
            slow_knob = b[0];
            do_cmd({5'h00, `FSP_CMD_ERASE}, 8'(b), 8'h00, 8'h00, {1'b0, b < 2},
                   1'b1);
        end
        slow_knob = 1'b0;
        check(flash_mem.mem[12'h000], 8'h00);
        check(flash_mem.mem[12'h200], 8'hFF);
        $display("test erase_protect done");
        bus_wr(`FSP_ADDR_WDATA, 8'hA5, 8'hFF);
        do_cmd({5'h00, `FSP_CMD_WRITE}, 8'h02, 8'h34, 8'h34, 2'b00, 1'b1);
        check(flash_mem.mem[12'h234], 8'hA5);
        bus_wr(`FSP_ADDR_WDATA, 8'h5A, 8'hFF);
        do_cmd({5'h00, `FSP_CMD_WRITE}, 8'h02, 8'h34, 8'h34, 2'b01, 1'b1);
        check(flash_mem.mem[12'h234], 8'hA5);
        $display("test byte_write done");
        do_cmd({5'h00, `FSP_CMD_BLANK}, 8'h02, 8'h00, 8'hFF, 2'b10, 1'b1);
        do_cmd({5'h00, `FSP_CMD_VERIFY2}, 8'h02, 8'h00, 8'h03, 2'b00, 1'b1);
        fail_knob = 1'b1;
        do_cmd({5'h00, `FSP_CMD_VERIFY1}, 8'h02, 8'h00, 8'hFF, 2'b10, 1'b1);
        fail_knob = 1'b0;
        do_cmd({5'h00, `FSP_CMD_ERASE}, 8'h02, 8'h00, 8'h00, 2'b00, 1'b1);
        do_cmd({5'h00, `FSP_CMD_BLANK}, 8'h02, 8'h00, 8'hFF, 2'b00, 1'b1);
        $display("test verify_blank done");
        for (int c = 6; c < 8; c++)
            do_cmd(8'(c), 8'h03, 8'h00, 8'h00, 2'b10, 1'b1);
        do_cmd(8'h00, 8'h03, 8'h00, 8'h00, 2'b00, 1'b0);
        self_mode = 1'b0;
        do_cmd({5'h00, `FSP_CMD_ERASE}, 8'h00, 8'h00, 8'h00, 2'b00, 1'b0);
        self_mode = 1'b1;
        check(flash_mem.mem[12'h000], 8'h00);
        $display("test refusals done");
        do_reset(8'hBB);
        bus_rd(`FSP_ADDR_CMD, `FSP_CMD_RESET);
        bus_rd(`FSP_ADDR_WDATA, `FSP_WDATA_RESET);
        do_cmd({5'h00, `FSP_CMD_ERASE}, 8'h03, 8'h00, 8'h00, 2'b01, 1'b1);
        do_reset(8'h83);
        do_cmd({5'h00, `FSP_CMD_ERASE}, 8'h03, 8'h00, 8'h00, 2'b01, 1'b1);
        do_reset(8'hFF);
        do_cmd({5'h00, `FSP_CMD_ERASE}, 8'h00, 8'h00, 8'h00, 2'b00, 1'b1);
        check(flash_mem.mem[12'h000], 8'hFF);
        $display("test protect_codes done");
        test_done;
    end
endmodule : testbench
`default_nettype wire
